// file: logic/iep_interrupt_enable_priority_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Each per-source enable bit blocks its request at 0 and lets it be accepted at 1.
// - Bit 7 of the timer two enable register gates the shared timer two overflow request.
// - Timer two enable bits 6..4 gate compare 2..0 and bits 3..0 gate capture 3..0.
// - Standard priority low/high registers hold converter, serial 1, serial 0, timer 1, ext 1, timer 0, ext 0 in bits 6..0, bit 7 unused.
// - Timer two priority low bit 7 sets overflow priority and bits 6..4 compare 2..0.
// - Timer two priority low bits 3..0 set capture 3..0 priority low bits.
// - Each source level is {high,low}: 00 level 0 lowest up to 11 level 3 highest.
// - The global enable overrides all: cleared accepts nothing, set accepts enabled sources.
// - A request preempts only service of a strictly lower level; otherwise it waits.
module iep_interrupt_enable_priority_regs (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [9:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [14:0] IRQ_FLAGS,
	input wire logic IRQ_ACK,
	input wire logic IRQ_RETURN,
	output logic IRQ_REQ,
	output logic [3:0] IRQ_SRC,
	output logic [1:0] IRQ_LEVEL,
	output logic [3:0] IN_SERVICE
);

	iep_pkg::iep_regs_t regs, next_regs;
	iep_pkg::iep_bus_state_t bus_state, next_bus_state;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [3:0] in_service, next_in_service;
	logic [3:0] irq_src, next_irq_src;
	logic [1:0] irq_level, next_irq_level;
	logic irq_req, next_irq_req;
	logic [14:0] enabled;
	logic [1:0] src_level [15];
	logic [3:0] best_src;
	logic [1:0] best_level;
	logic mapped;

	// Level of a source from its high and low priority bits
	function automatic logic [1:0] level_of(input logic high_bit, input logic low_bit);
		return {high_bit, low_bit};
	endfunction

	// Bit pickers for the checks; they index with the current source, not a delayed one
	function automatic logic bit_at(input logic [7:0] v, input logic [2:0] idx);
		return v[idx];
	endfunction

	function automatic logic flag_at(input logic [14:0] v, input logic [3:0] idx);
		return v[idx];
	endfunction

	// Highest level currently in service, or -1 style flag via valid bit
	function automatic logic [2:0] top_service(input logic [3:0] srv);
		logic [2:0] res;
		res = 3'b000;
		for (int i = 0; i < iep_pkg::NUM_LEVEL; i++) begin
			if (srv[i]) begin
				res = {1'b1, 2'(i)};
			end
		end
		return res;
	endfunction

	always_comb begin
		for (int i = 0; i < iep_pkg::T2_BASE; i++) begin
			enabled[i] = IRQ_FLAGS[i] & regs.std_en[i] & regs.global_en;
			src_level[i] = level_of(regs.std_high[i], regs.std_low[i]);
		end
		for (int j = 0; j < 8; j++) begin
			// Bit 7 overflow, 6..4 compare, 3..0 capture
			enabled[iep_pkg::T2_BASE + j] = IRQ_FLAGS[iep_pkg::T2_BASE + j]
				& regs.t2_en[j] & regs.global_en;
			src_level[iep_pkg::T2_BASE + j] = level_of(regs.t2_high[j], regs.t2_low[j]);
		end
	end

	// Lowest index wins inside a level; the documented in-level poll order is left to the core
	always_comb begin
		best_src = iep_pkg::SRC_NONE;
		best_level = 2'b00;
		for (int i = 0; i < iep_pkg::NUM_SRC; i++) begin
			if (enabled[i] && (best_src == iep_pkg::SRC_NONE || src_level[i] > best_level)) begin
				best_src = 4'(i);
				best_level = src_level[i];
			end
		end
	end

	always_comb begin
		logic [2:0] top;
		top = top_service(in_service);
		next_in_service = in_service;
		if (IRQ_RETURN && top[2]) begin
			next_in_service[top[1:0]] = 1'b0;
		end
		if (IRQ_ACK && irq_req) begin
			next_in_service[irq_level] = 1'b1;
		end
		next_irq_src = best_src;
		next_irq_level = best_level;
		// Preempt only a strictly lower level; equal waits for the return
		next_irq_req = (best_src != iep_pkg::SRC_NONE)
			&& (!top[2] || best_level > top[1:0]) && !(IRQ_ACK && irq_req);
	end

	always_comb begin
		case (PADDR)
			iep_pkg::ADDR_PRIO_HIGH_STD, iep_pkg::ADDR_PRIO_LOW_STD, iep_pkg::ADDR_GLOBAL_CTRL,
			iep_pkg::ADDR_STD_ENABLES, iep_pkg::ADDR_SERVICE_STATUS, iep_pkg::ADDR_PRIO_HIGH_T2,
			iep_pkg::ADDR_T2_ENABLES, iep_pkg::ADDR_PRIO_LOW_T2: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		next_regs = regs;
		next_prdata = PRDATA;
		next_pslverr = 1'b0;
		next_bus_state = iep_pkg::IEP_IDLE;
		case (bus_state)
			iep_pkg::IEP_IDLE: begin
				if (PSEL && !PENABLE) begin
					next_bus_state = iep_pkg::IEP_ACCESS;
					next_pslverr = !mapped;
					next_prdata = 32'h0000_0000;
					case (PADDR)
						iep_pkg::ADDR_PRIO_HIGH_STD: next_prdata[7:0] = regs.std_high;
						iep_pkg::ADDR_PRIO_LOW_STD: next_prdata[7:0] = regs.std_low;
						iep_pkg::ADDR_GLOBAL_CTRL: next_prdata[0] = regs.global_en;
						iep_pkg::ADDR_STD_ENABLES: next_prdata[7:0] = regs.std_en;
						iep_pkg::ADDR_SERVICE_STATUS: next_prdata[3:0] = in_service;
						iep_pkg::ADDR_PRIO_HIGH_T2: next_prdata[7:0] = regs.t2_high;
						iep_pkg::ADDR_T2_ENABLES: next_prdata[7:0] = regs.t2_en;
						iep_pkg::ADDR_PRIO_LOW_T2: next_prdata[7:0] = regs.t2_low;
						default: next_prdata = 32'h0000_0000;
					endcase
				end
			end
			iep_pkg::IEP_ACCESS: begin
				next_pslverr = PSLVERR;
				if (PWRITE) begin
					case (PADDR)
						iep_pkg::ADDR_PRIO_HIGH_STD: next_regs.std_high = PWDATA[7:0] & iep_pkg::STD_USED_MASK;
						iep_pkg::ADDR_PRIO_LOW_STD: next_regs.std_low = PWDATA[7:0] & iep_pkg::STD_USED_MASK;
						iep_pkg::ADDR_GLOBAL_CTRL: next_regs.global_en = PWDATA[iep_pkg::GLOBAL_EN_BIT];
						iep_pkg::ADDR_STD_ENABLES: next_regs.std_en = PWDATA[7:0] & iep_pkg::STD_USED_MASK;
						iep_pkg::ADDR_PRIO_HIGH_T2: next_regs.t2_high = PWDATA[7:0];
						iep_pkg::ADDR_T2_ENABLES: next_regs.t2_en = PWDATA[7:0];
						iep_pkg::ADDR_PRIO_LOW_T2: next_regs.t2_low = PWDATA[7:0];
						default: next_regs = regs;
					endcase
				end
			end
			default: next_bus_state = iep_pkg::IEP_IDLE;
		endcase
	end

	// Access phase always completes in one cycle
	assign PREADY = (bus_state == iep_pkg::IEP_ACCESS);

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			regs <= '0;
			bus_state <= iep_pkg::IEP_IDLE;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			in_service <= 4'h0;
			irq_src <= iep_pkg::SRC_NONE;
			irq_level <= 2'h0;
			irq_req <= 1'b0;
		end else begin
			regs <= next_regs;
			bus_state <= next_bus_state;
			PRDATA <= next_prdata;
			PSLVERR <= next_pslverr;
			in_service <= next_in_service;
			irq_src <= next_irq_src;
			irq_level <= next_irq_level;
			irq_req <= next_irq_req;
		end
	end

	assign IRQ_REQ = irq_req;
	assign IRQ_SRC = irq_src;
	assign IRQ_LEVEL = irq_level;
	assign IN_SERVICE = in_service;

	chk_global_blocks: assert property (@(posedge CLK) disable iff (!ARST_N)
		!regs.global_en |=> !irq_req) else $error("request with global enable clear");
	chk_enable_gates: assert property (@(posedge CLK) disable iff (!ARST_N)
		irq_req |-> flag_at($past(enabled), irq_src)) else $error("request from disabled source");
	chk_t2_overflow_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
		(irq_req && irq_src == 4'he) |-> $past(regs.t2_en[7])) else $error("overflow not gated");
	chk_level_map: assert property (@(posedge CLK) disable iff (!ARST_N)
		(irq_req && irq_src < 4'h7) |-> irq_level == {bit_at($past(regs.std_high), irq_src[2:0]),
		bit_at($past(regs.std_low), irq_src[2:0])}) else $error("level mismatch");
	chk_preempt_strict: assert property (@(posedge CLK) disable iff (!ARST_N)
		(irq_req && $past(top_service(in_service) >= 3'b100))
		|-> irq_level > $past(top_service(in_service) & 3'b011)) else $error("preempted equal level");
	chk_std_bit7_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
		!regs.std_low[7] && !regs.std_high[7] && !regs.std_en[7]) else $error("unused bit set");
	chk_t2_high_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		(bus_state == iep_pkg::IEP_ACCESS && PWRITE && PADDR == iep_pkg::ADDR_PRIO_HIGH_T2)
		|=> regs.t2_high == $past(PWDATA[7:0])) else $error("t2 high not written");
	chk_t2_low_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		(bus_state == iep_pkg::IEP_ACCESS && PWRITE && PADDR == iep_pkg::ADDR_PRIO_LOW_T2)
		|=> regs.t2_low == $past(PWDATA[7:0])) else $error("t2 low not written");
	chk_t2_en_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		(bus_state == iep_pkg::IEP_ACCESS && PWRITE && PADDR == iep_pkg::ADDR_T2_ENABLES)
		|=> regs.t2_en == $past(PWDATA[7:0])) else $error("t2 enables not written");

	// Source gating and level mapping, judged against the registers one edge back
	chk_req_has_flag: assert property (@(posedge CLK) disable iff (!ARST_N)
		irq_req
		|-> flag_at($past(IRQ_FLAGS), irq_src))
		else $error("request without pending flag");
	chk_none_no_req: assert property (@(posedge CLK) disable iff (!ARST_N)
		irq_src == iep_pkg::SRC_NONE
		|-> !irq_req)
		else $error("request with no source");
	chk_std_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
		(irq_req && irq_src < 4'h7)
		|-> bit_at($past(regs.std_en), irq_src[2:0]))
		else $error("standard source not enabled");
	chk_t2_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
		(irq_req && irq_src >= 4'h7 && irq_src != iep_pkg::SRC_NONE)
		|-> bit_at($past(regs.t2_en), 3'(irq_src - 4'h7)))
		else $error("timer two source not enabled");
	chk_t2_level_map: assert property (@(posedge CLK) disable iff (!ARST_N)
		(irq_req && irq_src >= 4'h7 && irq_src != iep_pkg::SRC_NONE)
		|-> irq_level == {bit_at($past(regs.t2_high), 3'(irq_src - 4'h7)),
		bit_at($past(regs.t2_low), 3'(irq_src - 4'h7))})
		else $error("timer two level mismatch");

	// Nesting bookkeeping with the core
	chk_ack_drops_req: assert property (@(posedge CLK) disable iff (!ARST_N)
		(IRQ_ACK && irq_req)
		|=> !irq_req)
		else $error("request held after ack");
	chk_ack_marks_level: assert property (@(posedge CLK) disable iff (!ARST_N)
		(IRQ_ACK && irq_req)
		|=> in_service[$past(irq_level)])
		else $error("accepted level not in service");
	chk_return_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
		(IRQ_RETURN && !IRQ_ACK && in_service != 4'h0)
		|=> $countones(in_service) == $past($countones(in_service)) - 1)
		else $error("return did not end one level");

	// Register writes and the bus answer
	chk_global_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		(bus_state == iep_pkg::IEP_ACCESS && PWRITE && PADDR == iep_pkg::ADDR_GLOBAL_CTRL)
		|=> regs.global_en == $past(PWDATA[iep_pkg::GLOBAL_EN_BIT]))
		else $error("global enable not written");
	chk_std_en_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		(bus_state == iep_pkg::IEP_ACCESS && PWRITE && PADDR == iep_pkg::ADDR_STD_ENABLES)
		|=> regs.std_en == ($past(PWDATA[7:0]) & iep_pkg::STD_USED_MASK))
		else $error("standard enables not written");
	chk_std_low_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		(bus_state == iep_pkg::IEP_ACCESS && PWRITE && PADDR == iep_pkg::ADDR_PRIO_LOW_STD)
		|=> regs.std_low == ($past(PWDATA[7:0]) & iep_pkg::STD_USED_MASK))
		else $error("standard low bits not written");
	chk_std_high_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		(bus_state == iep_pkg::IEP_ACCESS && PWRITE && PADDR == iep_pkg::ADDR_PRIO_HIGH_STD)
		|=> regs.std_high == ($past(PWDATA[7:0]) & iep_pkg::STD_USED_MASK))
		else $error("standard high bits not written");
	// A refused access must leave every enable and priority untouched
	chk_bad_addr_kept: assert property (@(posedge CLK) disable iff (!ARST_N)
		(PREADY && PSLVERR)
		|=> regs == $past(regs))
		else $error("unmapped access changed a register");
	chk_upper_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
		(PREADY && !PWRITE)
		|-> PRDATA[31:8] == 24'h000000)
		else $error("upper read data not zero");
	chk_ready_after_setup: assert property (@(posedge CLK) disable iff (!ARST_N)
		(bus_state == iep_pkg::IEP_IDLE && PSEL && !PENABLE)
		|=> PREADY)
		else $error("no ready after setup");

	cov_request: cover property (@(posedge CLK) disable iff (!ARST_N) irq_req);
	cov_preempt: cover property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_ACK && irq_req && in_service != 4'h0);
	cov_nest_return: cover property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_RETURN && $countones(in_service) > 1);
	cov_bad_addr: cover property (@(posedge CLK) disable iff (!ARST_N) PREADY && PSLVERR);
	cov_equal_wait: cover property (@(posedge CLK) disable iff (!ARST_N)
		!irq_req && best_src != iep_pkg::SRC_NONE && in_service != 4'h0);

endmodule

// file: logic/iep_pkg.sv
package iep_pkg;

	// Register indices; one aligned word each, so the byte address is four times the index
	localparam logic [7:0] IDX_PRIO_HIGH_STD = 8'hb7;
	localparam logic [7:0] IDX_PRIO_LOW_STD = 8'hb8;
	localparam logic [7:0] IDX_GLOBAL_CTRL = 8'hc0;
	localparam logic [7:0] IDX_STD_ENABLES = 8'hc4;
	localparam logic [7:0] IDX_SERVICE_STATUS = 8'hcc;
	localparam logic [7:0] IDX_PRIO_HIGH_T2 = 8'hd0;
	localparam logic [7:0] IDX_T2_ENABLES = 8'he8;
	localparam logic [7:0] IDX_PRIO_LOW_T2 = 8'hf8;

	// Byte addresses on APB; narrow data in bits 7:0, the rest reads zero
	localparam logic [9:0] ADDR_PRIO_HIGH_STD = {IDX_PRIO_HIGH_STD, 2'b00};
	localparam logic [9:0] ADDR_PRIO_LOW_STD = {IDX_PRIO_LOW_STD, 2'b00};
	localparam logic [9:0] ADDR_GLOBAL_CTRL = {IDX_GLOBAL_CTRL, 2'b00};
	localparam logic [9:0] ADDR_STD_ENABLES = {IDX_STD_ENABLES, 2'b00};
	localparam logic [9:0] ADDR_SERVICE_STATUS = {IDX_SERVICE_STATUS, 2'b00};
	localparam logic [9:0] ADDR_PRIO_HIGH_T2 = {IDX_PRIO_HIGH_T2, 2'b00};
	localparam logic [9:0] ADDR_T2_ENABLES = {IDX_T2_ENABLES, 2'b00};
	localparam logic [9:0] ADDR_PRIO_LOW_T2 = {IDX_PRIO_LOW_T2, 2'b00};

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] STD_USED_MASK = 8'h7f;
	localparam int GLOBAL_EN_BIT = 0;
	localparam int NUM_SRC = 15;
	localparam int NUM_LEVEL = 4;

	// Source index order: 0..6 standard (bit positions), 7..14 timer two bits 0..7
	localparam int T2_BASE = 7;
	localparam logic [3:0] SRC_NONE = 4'hf;

	typedef struct packed {
		logic [7:0] std_low;
		logic [7:0] std_high;
		logic [7:0] t2_low;
		logic [7:0] t2_high;
		logic [7:0] std_en;
		logic [7:0] t2_en;
		logic global_en;
	} iep_regs_t;

	typedef enum logic [1:0] {
		IEP_IDLE,
		IEP_ACCESS
	} iep_bus_state_t;

endpackage

// file: test/iep_core_model.sv
`timescale 1ns/1ps
module iep_core_model (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic IRQ_REQ,
	input wire logic ack_en,
	input wire logic [3:0] ack_wait,
	input wire logic ret_go,
	output logic IRQ_ACK,
	output logic IRQ_RETURN
);
	logic [3:0] cnt;
	// Acks only a standing request, after ack_wait idle cycles to mimic a slow core
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cnt <= 4'h0;
			IRQ_ACK <= 1'b0;
			IRQ_RETURN <= 1'b0;
		end else begin
			IRQ_RETURN <= ret_go;
			if (ack_en && IRQ_REQ && !IRQ_ACK && cnt == ack_wait) begin
				IRQ_ACK <= 1'b1;
				cnt <= 4'h0;
			end else begin
				IRQ_ACK <= 1'b0;
				cnt <= (ack_en && IRQ_REQ && !IRQ_ACK) ? cnt + 4'h1 : 4'h0;
			end
		end
	end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb;
	logic CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, ack_en = 0, ret_go = 0;
	logic IRQ_ACK, IRQ_RETURN, IRQ_REQ, PREADY, PSLVERR, er;
	logic [9:0] PADDR = 10'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic [14:0] IRQ_FLAGS = 15'h0;
	logic [3:0] IRQ_SRC, IN_SERVICE, ack_wait = 4'h0;
	logic [1:0] IRQ_LEVEL;
	int n_mismatch = 0, checks_done = 0;
	initial forever #10 CLK = ~CLK;
	iep_interrupt_enable_priority_regs uut (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ_FLAGS(IRQ_FLAGS), .IRQ_ACK(IRQ_ACK),
		.IRQ_RETURN(IRQ_RETURN), .IRQ_REQ(IRQ_REQ), .IRQ_SRC(IRQ_SRC), .IRQ_LEVEL(IRQ_LEVEL),
		.IN_SERVICE(IN_SERVICE));
	iep_core_model core (.CLK(CLK), .ARST_N(ARST_N), .IRQ_REQ(IRQ_REQ), .ack_en(ack_en),
		.ack_wait(ack_wait), .ret_go(ret_go), .IRQ_ACK(IRQ_ACK), .IRQ_RETURN(IRQ_RETURN));
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 16);
		`CHK(PREADY, 1'b1)
		rd = PRDATA; er = PSLVERR; PSEL <= 1'b0; PENABLE <= 1'b0;
	endtask
	task automatic settle();
		repeat (3) @(posedge CLK);
		#1;
	endtask
	task automatic wait_svc(input logic [3:0] v);
		int n;
		n = 0;
		while (IN_SERVICE !== v && n < 30) begin @(posedge CLK); #1; n++; end
		`CHK(IN_SERVICE, v)
	endtask
	task automatic test_regs();
		logic [9:0] ad [6];
		logic [7:0] ex;
		ad = '{iep_pkg::ADDR_PRIO_HIGH_STD, iep_pkg::ADDR_PRIO_LOW_STD, iep_pkg::ADDR_STD_ENABLES,
			iep_pkg::ADDR_PRIO_HIGH_T2, iep_pkg::ADDR_T2_ENABLES, iep_pkg::ADDR_PRIO_LOW_T2};
		for (int i = 0; i < 6; i++) begin
			ex = (i < 3) ? iep_pkg::STD_USED_MASK : 8'hff;
			apb(1'b0, ad[i], 32'h0); `CHK(rd, 32'h0)
			apb(1'b1, ad[i], 32'hffff_ffff);
			apb(1'b0, ad[i], 32'h0); `CHK(rd, {24'h0, ex})
			apb(1'b1, ad[i], 32'h0);
		end
		apb(1'b1, iep_pkg::ADDR_GLOBAL_CTRL, 32'hffff_ffff);
		apb(1'b0, iep_pkg::ADDR_GLOBAL_CTRL, 32'h0); `CHK(rd, 32'h1)
		apb(1'b1, iep_pkg::ADDR_GLOBAL_CTRL, 32'h0);
		apb(1'b0, 10'h010, 32'h0); `CHK(er, 1'b1)
		apb(1'b1, 10'h010, 32'hff); `CHK(er, 1'b1)
		apb(1'b0, iep_pkg::ADDR_T2_ENABLES, 32'h0); `CHK(rd, 32'h0)
		$display("test regs done");
	endtask
	task automatic test_enables();
		IRQ_FLAGS <= 15'h7fff;
		apb(1'b1, iep_pkg::ADDR_T2_ENABLES, 32'hff);
		settle(); `CHK(IRQ_REQ, 1'b0)
		apb(1'b1, iep_pkg::ADDR_GLOBAL_CTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, iep_pkg::ADDR_T2_ENABLES, 32'h1 << i);
			settle(); `CHK(IRQ_SRC, 4'(iep_pkg::T2_BASE + i))
		end
		apb(1'b1, iep_pkg::ADDR_T2_ENABLES, 32'h0);
		settle(); `CHK(IRQ_REQ, 1'b0)
		$display("test enables done");
	endtask
	task automatic test_levels();
		IRQ_FLAGS <= 15'h1;
		apb(1'b1, iep_pkg::ADDR_STD_ENABLES, 32'h1);
		for (int l = 0; l < 4; l++) begin
			apb(1'b1, iep_pkg::ADDR_PRIO_HIGH_STD, l >> 1);
			apb(1'b1, iep_pkg::ADDR_PRIO_LOW_STD, l & 1);
			settle(); `CHK(IRQ_LEVEL, 2'(l))
		end
		$display("test levels done");
	endtask
	task automatic test_preempt();
		apb(1'b1, iep_pkg::ADDR_PRIO_HIGH_STD, 32'h0);
		apb(1'b1, iep_pkg::ADDR_PRIO_LOW_STD, 32'h1);
		ack_en <= 1'b1; ack_wait <= 4'h2;
		wait_svc(4'b0010);
		IRQ_FLAGS <= 15'h4001;
		apb(1'b1, iep_pkg::ADDR_T2_ENABLES, 32'h80);
		apb(1'b1, iep_pkg::ADDR_PRIO_LOW_T2, 32'h80);
		settle(); `CHK(IRQ_REQ, 1'b0)
		apb(1'b1, iep_pkg::ADDR_PRIO_HIGH_T2, 32'h80);
		wait_svc(4'b1010);
		apb(1'b0, iep_pkg::ADDR_SERVICE_STATUS, 32'h0); `CHK(rd, 32'ha)
		IRQ_FLAGS <= 15'h0;
		@(posedge CLK) ret_go <= 1'b1;
		@(posedge CLK) ret_go <= 1'b0;
		wait_svc(4'b0010);
		$display("test preempt done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge CLK);
		ARST_N <= 1'b1;
		test_regs();
		test_enables();
		test_levels();
		test_preempt();
		print_verdict();
	end
	// Whole run needs well under 1000 cycles
	initial begin
		#100us;
		n_mismatch++;
		print_verdict();
	end
endmodule
